// ===== verilog/mpcr_top.sv
// management port control registers and in-band frame gate
`timescale 1ns/1ps
`default_nettype none
module mpcr_top
	import mpcr_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [11:0] I_REG_ADDR,
	input wire logic [3:0] I_REG_BE,
	input wire logic [31:0] I_REG_WDATA,
	output logic [31:0] O_REG_RDATA,
	input wire logic I_STRAP_LED_PIN,
	input wire logic I_SERIAL_CLK,
	input wire logic [47:0] I_SWITCH_MAC,
	input wire logic I_IB_FRAME_VALID,
	input wire logic [47:0] I_IB_DST_MAC,
	input wire logic [15:0] I_IB_ETYPE,
	input wire logic [2:0] I_IB_RX_PORT,
	output logic O_IB_ACCEPT,
	output logic O_IB_DISCARD,
	output logic O_IB_SM_INIT,
	output logic O_IB_ENABLE,
	output logic [1:0] O_IB_RESP_QUEUE,
	output logic [2:0] O_IB_PORT,
	output logic O_MGMT_BUS_PREAMBLE_REQ,
	output logic O_SERIAL_DATA_OUT_PIN_RISING
);
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] sio_ctrl;
	logic [31:0] iba_ctrl;
	logic [2:0] strap_sync;
	logic [1:0] strap_cnt;
	logic strap_done;
	mpcr_state_t state;
	logic [2:0] init_cnt;
	logic [31:0] rdata;
	logic sclk_fast;

	logic [7:0] next_sio_ctrl;
	logic [31:0] next_iba_ctrl;
	logic [2:0] next_strap_sync;
	logic [1:0] next_strap_cnt;
	logic next_strap_done;
	mpcr_state_t next_state;
	logic [2:0] next_init_cnt;
	logic [31:0] next_rdata;
	logic next_accept;
	logic next_discard;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	mpcr_sclk_rate #(
		.CNT_W(8)
	) u_rate (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_sclk(I_SERIAL_CLK),
		.o_fast(sclk_fast)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register file, strap capture and in-band state machine
	always_comb begin
		next_sio_ctrl = sio_ctrl;
		next_iba_ctrl = iba_ctrl;
		next_strap_sync = {strap_sync[1:0], I_STRAP_LED_PIN};
		next_strap_cnt = strap_cnt;
		next_strap_done = strap_done;
		next_state = state;
		next_init_cnt = init_cnt;
		next_rdata = rdata;
		next_accept = 1'b0;
		next_discard = 1'b0;

		// strap caught once the synchroniser has filled after reset release
		if (!strap_done) begin
			if (strap_cnt == 2'(STRAP_SETTLE_CYC - 1) && strap_sync[1] == strap_sync[2]) begin
				next_iba_ctrl[IBA_EN_BIT] = ~strap_sync[2];
				next_strap_done = 1'b1;
			end else if (strap_cnt != 2'(STRAP_SETTLE_CYC - 1)) begin
				next_strap_cnt = strap_cnt + 2'h1;
			end
		end

		if (I_REG_WR && I_REG_ADDR == SIO_CTRL_OFS && I_REG_BE[0]) begin
			next_sio_ctrl = I_REG_WDATA[7:0];
		end
		if (I_REG_WR && I_REG_ADDR == IBA_CTRL_OFS) begin
			next_iba_ctrl = (be_merge(iba_ctrl, I_REG_WDATA, I_REG_BE) & IBA_WMASK)
				| (next_iba_ctrl & ~IBA_WMASK);
			if (I_REG_BE[3] && I_REG_WDATA[IBA_EN_BIT]) begin
				next_strap_done = 1'b1;
			end else if (I_REG_BE[3]) begin
				next_strap_done = 1'b1;
			end
			if (I_REG_BE[2] && I_REG_WDATA[IBA_PORT_LSB +: 3] > IBA_PORT_LAST) begin
				// reserved port codes are refused, the field keeps its value
				next_iba_ctrl[IBA_PORT_LSB +: 3] = iba_ctrl[IBA_PORT_LSB +: 3];
			end
		end

		unique case (state)
			MPCR_ST_IDLE: begin
				if (iba_ctrl[IBA_RST_BIT]) begin
					next_state = MPCR_ST_INIT;
					next_init_cnt = 3'h0;
				end else if (I_IB_FRAME_VALID && iba_ctrl[IBA_EN_BIT]
					&& I_IB_ETYPE == iba_ctrl[15:0]
					&& I_IB_RX_PORT == iba_ctrl[IBA_PORT_LSB +: 3]) begin
					if (iba_ctrl[IBA_MATCH_BIT] && I_IB_DST_MAC != I_SWITCH_MAC) begin
						next_discard = 1'b1;
					end else begin
						next_accept = 1'b1;
					end
				end
			end
			MPCR_ST_INIT: begin
				next_init_cnt = init_cnt + 3'h1;
				if (init_cnt == 3'(IBA_INIT_CYC - 1)) begin
					next_state = MPCR_ST_IDLE;
					next_iba_ctrl[IBA_RST_BIT] = 1'b0;
				end
			end
			default: begin
				next_state = MPCR_ST_IDLE;
			end
		endcase

		if (I_REG_RD) begin
			if (I_REG_ADDR == SIO_CTRL_OFS) begin
				next_rdata = {24'h0, sio_ctrl};
			end else if (I_REG_ADDR == IBA_CTRL_OFS) begin
				next_rdata = iba_ctrl;
			end else begin
				next_rdata = 32'h0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sio_ctrl <= SIO_CTRL_RST;
			iba_ctrl <= {8'h0, IBA_QUEUE_RST, 3'h0, IBA_PORT_RST, IBA_ETYPE_RST};
			strap_sync <= 3'h0;
			strap_cnt <= 2'h0;
			strap_done <= 1'b0;
			state <= MPCR_ST_IDLE;
			init_cnt <= 3'h0;
			rdata <= 32'h0;
			O_IB_ACCEPT <= 1'b0;
			O_IB_DISCARD <= 1'b0;
		end else begin
			sio_ctrl <= next_sio_ctrl;
			iba_ctrl <= next_iba_ctrl;
			strap_sync <= next_strap_sync;
			strap_cnt <= next_strap_cnt;
			strap_done <= next_strap_done;
			state <= next_state;
			init_cnt <= next_init_cnt;
			rdata <= next_rdata;
			O_IB_ACCEPT <= next_accept;
			O_IB_DISCARD <= next_discard;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign O_REG_RDATA = rdata;
	assign O_IB_SM_INIT = (state == MPCR_ST_INIT);
	assign O_IB_ENABLE = iba_ctrl[IBA_EN_BIT];
	assign O_IB_RESP_QUEUE = iba_ctrl[IBA_QUEUE_LSB +: 2];
	assign O_IB_PORT = iba_ctrl[IBA_PORT_LSB +: 3];
	// only the management bus sees this; serial ports ignore it
	assign O_MGMT_BUS_PREAMBLE_REQ = ~sio_ctrl[SIO_PREAMBLE_BIT];
	assign O_SERIAL_DATA_OUT_PIN_RISING = sio_ctrl[SIO_AUTO_BIT] ? sclk_fast
		: sio_ctrl[SIO_EDGE_BIT];
endmodule
`default_nettype wire

// ===== inc/mpcr_pkg.sv
// package with constants for the management port control registers
package mpcr_pkg;
	localparam logic [11:0] SIO_CTRL_OFS = 12'h100;
	localparam logic [11:0] IBA_CTRL_OFS = 12'h104;
	localparam logic [7:0] SIO_CTRL_RST = 8'h42;
	localparam int SIO_PREAMBLE_BIT = 2;
	localparam int SIO_AUTO_BIT = 1;
	localparam int SIO_EDGE_BIT = 0;
	localparam int IBA_EN_BIT = 31;
	localparam int IBA_MATCH_BIT = 30;
	localparam int IBA_RST_BIT = 29;
	localparam int IBA_QUEUE_LSB = 22;
	localparam int IBA_PORT_LSB = 16;
	localparam logic [1:0] IBA_QUEUE_RST = 2'h1;
	localparam logic [2:0] IBA_PORT_RST = 3'h0;
	localparam logic [2:0] IBA_PORT_LAST = 3'h2;
	localparam logic [15:0] IBA_ETYPE_RST = 16'h40FE;
	localparam logic [31:0] IBA_WMASK = 32'hE0C7FFFF;
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int SCLK_FAST_HZ = 25_000_000;
	localparam int SCLK_FAST_CYC = SYS_CLK_HZ / SCLK_FAST_HZ;
	localparam int IBA_INIT_CYC = 4;
	localparam int STRAP_SETTLE_CYC = 3;
	typedef enum logic [1:0] {
		MPCR_ST_IDLE = 2'b01,
		MPCR_ST_INIT = 2'b10
	} mpcr_state_t;
endpackage

// ===== verilog/mpcr_sclk_rate.sv
// serial clock synchroniser and rate detector
`timescale 1ns/1ps
`default_nettype none
module mpcr_sclk_rate
	import mpcr_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_sclk,
	output logic o_fast
);
	logic [2:0] sync;
	logic stable;
	logic [CNT_W-1:0] cnt;
	logic [2:0] next_sync;
	logic next_stable;
	logic [CNT_W-1:0] next_cnt;
	logic next_fast;

	always_comb begin
		next_sync = {sync[1:0], i_sclk};
		next_stable = stable;
		if (sync[1] == sync[2]) begin
			next_stable = sync[2];
		end
		next_cnt = cnt;
		if (cnt != {CNT_W{1'b1}}) begin
			next_cnt = cnt + 1'b1;
		end
		next_fast = o_fast;
		// period measured between rising edges; a stopped clock keeps the decision
		if (next_stable && !stable) begin
			next_fast = (32'(cnt) + 1 <= SCLK_FAST_CYC);
			next_cnt = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync <= 3'h0;
			stable <= 1'b0;
			cnt <= '0;
			o_fast <= 1'b0;
		end else begin
			sync <= next_sync;
			stable <= next_stable;
			cnt <= next_cnt;
			o_fast <= next_fast;
		end
	end
endmodule
`default_nettype wire

// ===== verif/mpcr_host_model.sv
// host side model: serial clock at 160 ns, held low between frames
`timescale 1ns/1ps
`default_nettype none
module mpcr_host_model (
	input wire logic i_run,
	output logic o_sclk
);
	initial o_sclk = 1'b0;
	always #80 o_sclk = i_run ? ~o_sclk : 1'b0;
endmodule
`default_nettype wire

// ===== verif/mpcr_monitor.sv
// concurrent checks on the management port control register ports
`timescale 1ns/1ps
`default_nettype none
module mpcr_monitor (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_REG_WR,
	input wire logic [11:0] I_REG_ADDR,
	input wire logic [3:0] I_REG_BE,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic [47:0] I_SWITCH_MAC,
	input wire logic I_IB_FRAME_VALID,
	input wire logic [47:0] I_IB_DST_MAC,
	input wire logic O_IB_ACCEPT,
	input wire logic O_IB_DISCARD,
	input wire logic O_IB_SM_INIT,
	input wire logic O_IB_ENABLE,
	input wire logic [1:0] O_IB_RESP_QUEUE,
	input wire logic [2:0] O_IB_PORT,
	input wire logic O_MGMT_BUS_PREAMBLE_REQ,
	input wire logic O_SERIAL_DATA_OUT_PIN_RISING
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	wire logic sio_wr = I_REG_WR && I_REG_ADDR == 12'h100 && I_REG_BE[0];
	wire logic iba_wr = I_REG_WR && I_REG_ADDR == 12'h104;
	AST_PREAMBLE: assert property (
		sio_wr |=> O_MGMT_BUS_PREAMBLE_REQ == !$past(I_REG_WDATA[2])) else $error("preamble");
	AST_MANUAL_EDGE: assert property (
		sio_wr && !I_REG_WDATA[1] |=> O_SERIAL_DATA_OUT_PIN_RISING == $past(I_REG_WDATA[0]))
		else $error("manual edge");
	AST_INIT_RUN: assert property (
		iba_wr && I_REG_BE[3] && I_REG_WDATA[29] && !O_IB_SM_INIT
		|=> ##1 O_IB_SM_INIT [*4] ##1 !O_IB_SM_INIT) else $error("init length");
	AST_ENABLE: assert property (
		iba_wr && I_REG_BE[3] |=> O_IB_ENABLE == $past(I_REG_WDATA[31])) else $error("enable");
	AST_QUEUE: assert property (
		iba_wr && I_REG_BE[2] |=> O_IB_RESP_QUEUE == $past(I_REG_WDATA[23:22]))
		else $error("queue");
	AST_PORT_KEEP: assert property (
		iba_wr && I_REG_BE[2] && I_REG_WDATA[18:16] > 3'h2 |=> $stable(O_IB_PORT))
		else $error("reserved port");
	AST_GATE: assert property (
		O_IB_ACCEPT || O_IB_DISCARD |-> $past(I_IB_FRAME_VALID && O_IB_ENABLE && !O_IB_SM_INIT))
		else $error("frame gate");
	AST_DISCARD: assert property (
		O_IB_DISCARD |-> $past(I_IB_DST_MAC != I_SWITCH_MAC)) else $error("discard");
	AST_EXCL: assert property (
		!(O_IB_ACCEPT && O_IB_DISCARD)) else $error("accept and discard");
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the management port control registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mpcr_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, vld = 1'b0, strap = 1'b0, run = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [3:0] be = 4'h0;
	logic [31:0] wd = 32'h0, rdata;
	logic [47:0] mac = 48'h0A1B2C3D4E5F, dmac = 48'h0;
	logic [15:0] ety = 16'h0;
	logic [2:0] rxp = 3'h0, port;
	logic [1:0] que;
	logic sclk, acc, dis, init, en, pre, rise;
	int fails = 0, tests_run = 0, sio, in_band_access, r;
	always #10 clk = ~clk;
	mpcr_host_model host (.i_run(run), .o_sclk(sclk));
	mpcr_top uut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_REG_WR(wr), .I_REG_RD(rd),
		.I_REG_ADDR(addr), .I_REG_BE(be), .I_REG_WDATA(wd), .O_REG_RDATA(rdata),
		.I_STRAP_LED_PIN(strap), .I_SERIAL_CLK(sclk), .I_SWITCH_MAC(mac),
		.I_IB_FRAME_VALID(vld), .I_IB_DST_MAC(dmac), .I_IB_ETYPE(ety), .I_IB_RX_PORT(rxp),
		.O_IB_ACCEPT(acc), .O_IB_DISCARD(dis), .O_IB_SM_INIT(init), .O_IB_ENABLE(en),
		.O_IB_RESP_QUEUE(que), .O_IB_PORT(port), .O_MGMT_BUS_PREAMBLE_REQ(pre),
		.O_SERIAL_DATA_OUT_PIN_RISING(rise));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wreg(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		be <= b;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", rdata, e);
	endtask
	// one header pulse, then the registered verdict {accept, discard}
	task automatic frame(input logic [47:0] m, input logic [15:0] t, input logic [2:0] p,
		input logic [1:0] e);
		@(posedge clk);
		vld <= 1'b1;
		rxp <= p;
		dmac <= m;
		ety <= t;
		@(posedge clk);
		vld <= 1'b0;
		@(negedge clk);
		chk("frame", {acc, dis}, e);
	endtask
	task automatic wait_init(input logic v);
		int n;
		n = 0;
		while (init !== v) begin
			@(negedge clk);
			n++;
			if (n > 20) begin
				fails++;
				complete_run;
			end
		end
	endtask
	initial begin
		r = $urandom(51);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		sio = SIO_CTRL_RST;
		in_band_access = {16'h8040, IBA_ETYPE_RST};
		rreg(SIO_CTRL_OFS, sio);
		rreg(IBA_CTRL_OFS, in_band_access);
		chk("enable", en, 1'b1);
		chk("preamble", pre, 1'b1);
		run <= 1'b1;
		repeat (40) @(posedge clk);
		chk("edge", rise, 1'b0);
		run <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			sio = 8'h40 | i;
			wreg(SIO_CTRL_OFS, 4'h1, sio);
			@(negedge clk);
			chk("preamble", pre, !i[2]);
			chk("edge", rise, i[1:0] == 2'b01);
			rreg(SIO_CTRL_OFS, sio);
		end
		for (int i = 0; i < 6; i++) begin
			r = $urandom & 32'hDFFFFFFF;
			wreg(IBA_CTRL_OFS, 4'hF, r);
			in_band_access = (r & 32'hC0C0FFFF) | ((r[18:16] > 3'h2 ? in_band_access : r) & 32'h70000);
			rreg(IBA_CTRL_OFS, in_band_access);
			chk("queue", que, in_band_access[23:22]);
			chk("port", port, in_band_access[18:16]);
		end
		rreg(12'h108, 32'h0);
		in_band_access = 32'h80010000 | ($urandom & 32'hFFFF);
		wreg(IBA_CTRL_OFS, 4'hF, in_band_access);
		frame(mac + 1, in_band_access[15:0], 3'h1, 2'b10);
		frame(mac, in_band_access[15:0] ^ 16'h1, 3'h1, 2'b00);
		frame(mac, in_band_access[15:0], 3'h0, 2'b00);
		wreg(IBA_CTRL_OFS, 4'h8, 32'hC0000000);
		frame(mac + 1, in_band_access[15:0], 3'h1, 2'b01);
		frame(mac, in_band_access[15:0], 3'h1, 2'b10);
		wreg(IBA_CTRL_OFS, 4'h8, 32'hA0000000);
		in_band_access = (in_band_access & 32'h00FFFFFF) | 32'h80000000;
		wait_init(1'b1);
		frame(mac, in_band_access[15:0], 3'h1, 2'b00);
		wait_init(1'b0);
		rreg(IBA_CTRL_OFS, in_band_access);
		frame(mac + 1, in_band_access[15:0], 3'h1, 2'b10);
		@(posedge clk);
		strap <= 1'b1;
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		chk("enable", en, 1'b0);
		complete_run;
	end
endmodule
bind mpcr_top mpcr_monitor mon (.*);
`default_nettype wire
